// ===== inc/ipc_pkg.sv
// Package: constants and types for the interprocessor communication register block
package ipc_pkg;
  // AHB-Lite
  localparam logic [1:0] IPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] IPC_HTRANS_SEQ = 2'h3;
  // Register byte offsets on the AHB-Lite port
  localparam logic [7:0] IPC_ICR_OFF = 8'h00;
  localparam logic [7:0] IPC_MAP_OFF = 8'h04;
  localparam logic [7:0] IPC_CTRL_OFF = 8'h08;
  localparam logic [7:0] IPC_IRQ_STAT_OFF = 8'h0c;
  localparam logic [7:0] IPC_IRQ_MASK_OFF = 8'h10;
  localparam logic [7:0] IPC_ERR_OFF = 8'h14;
  // Shared-bus I/O page addresses of the register, one per strap (22-bit, octal 17777500 + 2n)
  localparam logic [21:0] IPC_ICR_BUS_BASE = 22'h3fff40;
  // Field positions in the communication register
  localparam int IPC_RQ_BIT = 0;
  localparam int IPC_EAE_BIT = 5;
  localparam int IPC_IE_BIT = 6;
  localparam int IPC_HLT_BIT = 8;
  localparam int IPC_QPE_BIT = 15;
  // Doorbell interrupt identity
  localparam logic [4:0] IPC_DB_IPL = 5'h14;
  localparam logic [15:0] IPC_DB_VECTOR = 16'h0204;
  // Map geometry: 8 KB pages of the 22-bit bus space, 512 entries
  localparam int IPC_MAP_ENTRIES = 512;
  localparam int IPC_PAGE_BITS = 13;
  localparam int IPC_BUS_AW = 22;
  localparam int IPC_MEM_AW = 24;
  // Interrupt status bits
  localparam int IPC_EV_DB = 0;
  localparam int IPC_EV_PE = 1;
  localparam int IPC_EV_HLT = 2;
  // Reset values
  localparam logic [2:0] IPC_MASK_RST = 3'h0;
  localparam logic [1:0] IPC_ROLE_ARBITER = 2'h0;

  // One access from the shared bus, as seen by this board
  typedef struct packed {
    logic valid;
    logic write;
    logic byte_en;
    logic [IPC_BUS_AW-1:0] addr;
    logic [15:0] wdata;
  } ipc_bus_req_t;

  // Map entry: enable and private-memory page frame
  typedef struct packed {
    logic en;
    logic [IPC_MEM_AW-IPC_PAGE_BITS-1:0] frame;
  } ipc_map_ent_t;

  typedef enum logic [1:0] {
    IPC_ST_IDLE = 2'b00,
    IPC_ST_DATA = 2'b01
  } ipc_ahb_st_t;
endpackage : ipc_pkg

// ===== rtl/ipc_comm_reg.sv
// Interprocessor communication register, bus map gate and AHB-Lite register port
// Functional notes
// - A doorbell set by another master raises an interrupt at level 14 hex, vector 204 hex, off the bus lines.
// - With external access enabled, bus masters reach private memory through the map.
// - With external access disabled, private memory answers no bus address cycle.
// - An auxiliary halts when another master sets its halt bit; masters use this at power-up for boot order.
// - A parity error during an external private-memory access is flagged in the register.
// - The register is decoded in the bus I/O page and accepts any bus master.
// - Byte and word accesses are both supported on the register.
// - Each board straps as arbiter or one of three auxiliaries, four at most.
// - Each strap decodes the register at its own distinct bus address.
// - The map turns a 22-bit bus address into a 24-bit private-memory address.
// - Each map entry has an enable; a disabled entry does not respond, an enabled one steers the transfer.
// - Local processor memory traffic uses its own interconnect and makes no bus activity.
// - Doorbell request sets on a one write only while enabled, clears on grant, held clear while disabled.
// - Doorbell and access enables are writable only while local processor is master; reset clears them.
// - On an auxiliary the halt bit is read-write and halts; on the arbiter it reads zero.
// - The parity error bit is read-only and mirrors the memory system DMA parity flag.
`timescale 1ns/100ps
module ipc_comm_reg
  import ipc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Board straps and power
  input wire logic [1:0] role_strap,
  input wire logic dc_power_good,
  input wire logic bus_init,
  input wire logic local_is_master,
  // Shared-bus slave side
  input wire ipc_bus_req_t bus_req,
  output logic bus_reply,
  output logic [15:0] bus_rdata,
  // Private memory port for external accesses
  output logic mem_req,
  output logic mem_write,
  output logic [IPC_MEM_AW-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_parity_err,
  // Local processor side
  input wire logic db_grant,
  output logic db_irq,
  output logic [4:0] interrupt_priority_level,
  output logic [15:0] db_vector,
  output logic auxiliary_halt,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers (three stages, second and third must agree)
  logic [2:0] pg_s, bi_s;
  logic pg_q, bi_q, pg_q_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pg_s <= 3'h0;
      bi_s <= 3'h0;
      pg_q <= 1'b0;
      bi_q <= 1'b0;
      pg_q_d <= 1'b0;
    end else begin
      pg_s <= {pg_s[1:0], dc_power_good};
      bi_s <= {bi_s[1:0], bus_init};
      if (pg_s[1] == pg_s[2]) pg_q <= pg_s[2];
      if (bi_s[1] == bi_s[2]) bi_q <= bi_s[2];
      pg_q_d <= pg_q;
    end
  end
  // Power-good negation or bus initialise clears the enables
  wire logic init_clr = (pg_q_d & ~pg_q) | bi_q;

  // Strap caught after reset release, not by the async reset
  logic [1:0] role_r;
  logic role_ok;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      role_r <= IPC_ROLE_ARBITER;
      role_ok <= 1'b0;
    end else if (!role_ok) begin
      role_r <= role_strap;
      role_ok <= 1'b1;
    end
  end
  wire logic is_aux = (role_r != IPC_ROLE_ARBITER);

  function automatic logic [21:0] icr_bus_addr(input logic [1:0] role);
    icr_bus_addr = IPC_ICR_BUS_BASE + {19'h0, role, 1'b0};
  endfunction : icr_bus_addr

  ////////////////////////////////////////////////////////////////////////
  // Communication register state
  logic doorbell_request, doorbell_enable, local_mem_ext_access_en, halt_r, qpe_r;
  logic [IPC_MAP_ENTRIES-1:0] map_en;
  logic [IPC_MEM_AW-IPC_PAGE_BITS-1:0] map_frame [IPC_MAP_ENTRIES];

  // Shared-bus decode of the register
  // Own register address for the latched strap
  wire logic [21:0] icr_addr = icr_bus_addr(role_r);
  wire logic bus_icr_hit = bus_req.valid && (bus_req.addr[21:1] == icr_addr[21:1]);
  wire logic bus_wr_lo = bus_icr_hit && bus_req.write && (!bus_req.byte_en || !bus_req.addr[0]);
  wire logic bus_wr_hi = bus_icr_hit && bus_req.write && (!bus_req.byte_en || bus_req.addr[0]);

  // AHB-Lite address phase capture
  logic ph_wr, ph_rd;
  logic [7:0] ph_addr;
  logic [3:0] ph_be;
  wire logic ahb_go = hsel && hready && (htrans == IPC_HTRANS_NONSEQ || htrans == IPC_HTRANS_SEQ);

  function automatic logic [3:0] byte_lanes(input logic [2:0] sz, input logic [1:0] a);
    if (sz == 3'h0) byte_lanes = 4'h1 << a;
    else if (sz == 3'h1) byte_lanes = a[1] ? 4'hc : 4'h3;
    else byte_lanes = 4'hf;
  endfunction : byte_lanes

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h0;
      ph_be <= 4'h0;
    end else begin
      ph_wr <= ahb_go && hwrite;
      ph_rd <= ahb_go && !hwrite;
      if (ahb_go) begin
        ph_addr <= {haddr[7:2], 2'b00};
        ph_be <= byte_lanes(hsize, haddr[1:0]);
      end
    end
  end

  wire logic ahb_wr_lo = ph_wr && ph_addr == IPC_ICR_OFF && ph_be[0];
  wire logic ahb_wr_hi = ph_wr && ph_addr == IPC_ICR_OFF && ph_be[1];
  wire logic wr_lo = ahb_wr_lo || bus_wr_lo;
  wire logic wr_hi = ahb_wr_hi || bus_wr_hi;
  wire logic [15:0] wdat = ahb_wr_lo || ahb_wr_hi ? hwdata[15:0] : bus_req.wdata;

  // Enables: only while local processor owns the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      doorbell_enable <= 1'b0;
      local_mem_ext_access_en <= 1'b0;
    end else if (init_clr) begin
      doorbell_enable <= 1'b0;
      local_mem_ext_access_en <= 1'b0;
    end else if (wr_lo && local_is_master) begin
      doorbell_enable <= wdat[IPC_IE_BIT];
      local_mem_ext_access_en <= wdat[IPC_EAE_BIT];
    end
  end

  // Doorbell request: set on one write while enabled, clear on grant
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) doorbell_request <= 1'b0;
    else if (!doorbell_enable) doorbell_request <= 1'b0;
    else if (wr_lo && wdat[IPC_RQ_BIT]) doorbell_request <= 1'b1;
    else if (db_grant) doorbell_request <= 1'b0;
  end

  // Halt bit lives only on an auxiliary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) halt_r <= 1'b0;
    else if (!is_aux || init_clr) halt_r <= 1'b0;
    else if (wr_hi) halt_r <= wdat[IPC_HLT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus map and external private-memory access
  wire logic [8:0] map_idx = bus_req.addr[IPC_BUS_AW-1:IPC_PAGE_BITS];
  wire logic map_hit = bus_req.valid && !bus_icr_hit && local_mem_ext_access_en && map_en[map_idx];
  logic ext_acc_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) map_en <= '0;
    else if (ph_wr && ph_addr == IPC_MAP_OFF && ph_be[3]) map_en[hwdata[24:16]] <= hwdata[31];
  end
  always_ff @(posedge hclk) begin
    if (ph_wr && ph_addr == IPC_MAP_OFF && ph_be[1:0] == 2'h3) map_frame[hwdata[24:16]] <= hwdata[10:0];
  end

  // Memory port sees only map hits; local CPU traffic never appears here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= 16'h0;
      ext_acc_d <= 1'b0;
    end else begin
      mem_req <= map_hit;
      mem_write <= bus_req.write;
      mem_addr <= {map_frame[map_idx], bus_req.addr[IPC_PAGE_BITS-1:0]};
      mem_wdata <= bus_req.wdata;
      ext_acc_d <= map_hit;
    end
  end

  // DMA parity flag of the memory error register, cleared by software write-one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) qpe_r <= 1'b0;
    else if (ext_acc_d && mem_parity_err) qpe_r <= 1'b1;
    else if (ph_wr && ph_addr == IPC_ERR_OFF && ph_be[0] && hwdata[4]) qpe_r <= 1'b0;
  end

  wire logic [15:0] icr_val = {qpe_r, 6'h0, halt_r & is_aux, 1'b0, doorbell_enable,
                               local_mem_ext_access_en, 4'h0, doorbell_request};

  // Shared-bus reply: register access or memory-path strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reply <= 1'b0;
      bus_rdata <= 16'h0;
    end else begin
      bus_reply <= bus_icr_hit || map_hit;
      bus_rdata <= bus_icr_hit ? icr_val : 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Processor-side outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      db_irq <= 1'b0;
      interrupt_priority_level <= 5'h0;
      db_vector <= 16'h0;
      auxiliary_halt <= 1'b0;
    end else begin
      db_irq <= doorbell_request && !db_grant;
      interrupt_priority_level <= IPC_DB_IPL;
      db_vector <= IPC_DB_VECTOR;
      auxiliary_halt <= halt_r && is_aux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status, read-to-clear; set wins over the clearing read
  logic [2:0] ev_stat, ev_mask;
  logic req_d, pe_d;
  wire logic stat_rd = ph_rd && ph_addr == IPC_IRQ_STAT_OFF;
  wire logic [2:0] ev_set = {halt_r & ~auxiliary_halt, qpe_r & ~pe_d, doorbell_request & ~req_d};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_stat <= 3'h0;
      ev_mask <= IPC_MASK_RST;
      req_d <= 1'b0;
      pe_d <= 1'b0;
      irq <= 1'b0;
    end else begin
      req_d <= doorbell_request;
      pe_d <= qpe_r;
      ev_stat <= (stat_rd ? 3'h0 : ev_stat) | ev_set;
      if (ph_wr && ph_addr == IPC_IRQ_MASK_OFF && ph_be[0]) ev_mask <= hwdata[2:0];
      irq <= |(ev_stat & ev_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite data phase: zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ahb_go && !hwrite) begin
      if (haddr[7:2] == IPC_ICR_OFF[7:2]) hrdata <= {16'h0, icr_val};
      else if (haddr[7:2] == IPC_CTRL_OFF[7:2]) hrdata <= {29'h0, is_aux, role_r};
      else if (haddr[7:2] == IPC_IRQ_STAT_OFF[7:2]) hrdata <= {29'h0, ev_stat};
      else if (haddr[7:2] == IPC_IRQ_MASK_OFF[7:2]) hrdata <= {29'h0, ev_mask};
      else if (haddr[7:2] == IPC_ERR_OFF[7:2]) hrdata <= {27'h0, qpe_r, 4'h0};
      else hrdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_rq_held_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    !doorbell_enable |=> !doorbell_request) else $error("doorbell request set while disabled");
  a_rq_grant_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    doorbell_request && db_grant && !wr_lo |=> !doorbell_request) else $error("grant did not clear");
  a_db_irq_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    doorbell_request && !db_grant |=> db_irq && db_vector == 16'h0204) else $error("doorbell irq missing");
  a_eae_gate_mem: assert property (@(posedge hclk) disable iff (!hresetn)
    !local_mem_ext_access_en |=> !mem_req) else $error("memory answered while gated");
  a_map_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_req.valid && !map_en[map_idx] |=> !mem_req) else $error("disabled map entry hit");
  a_arb_halt_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    role_ok && !is_aux |=> !auxiliary_halt && !icr_val[IPC_HLT_BIT]) else $error("arbiter halt set");
  a_en_locked: assert property (@(posedge hclk) disable iff (!hresetn)
    !local_is_master && !init_clr |=> $stable(doorbell_enable)) else $error("enable changed by peer");
  sequence s_ext_parity;
    ext_acc_d && mem_parity_err;
  endsequence
  a_parity_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ext_parity |=> qpe_r ##1 bus_rdata[IPC_QPE_BIT] || !$past(bus_icr_hit)) else $error("parity not flagged");
  a_icr_reply: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_icr_hit |=> bus_reply) else $error("register did not reply");
endmodule : ipc_comm_reg

// ===== verification/ipc_peer_model.sv
// Peer bus master and private memory model on the shared-bus side
`timescale 1ns/100ps
module ipc_peer_model
  import ipc_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Shared bus
  output ipc_bus_req_t bus_req,
  input wire logic bus_reply,
  input wire logic [15:0] bus_rdata,
  // Private memory
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [IPC_MEM_AW-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_parity_err
);
  logic pe_inject;
  logic last_wr;
  logic [15:0] last_wd;
  logic [IPC_MEM_AW-1:0] last_addr;
  int hits;
  initial begin
    bus_req = '0;
    pe_inject = 1'b0;
    hits = 0;
  end
  ////////////////////////////////////////////////////////////
  // Parity answers in the strobe cycle, where the design looks for it
  always_comb mem_parity_err = mem_req & pe_inject;
  always @(posedge hclk) begin
    if (mem_req === 1'b1) begin
      hits++;
      last_addr <= mem_addr;
      last_wr <= mem_write;
      last_wd <= mem_wdata;
    end
  end
  ////////////////////////////////////////////////////////////
  // Released fields show inverted stale values, never the last ones
  task automatic access(input logic wr, input logic be, input logic [21:0] a, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
    ok = 1'b0;
    rd = 16'hffff;
    @(posedge hclk);
    bus_req <= '{valid: 1'b1, write: wr, byte_en: be, addr: a, wdata: wd};
    @(posedge hclk);
    bus_req <= '{valid: 1'b0, write: ~wr, byte_en: ~be, addr: ~a, wdata: ~wd};
    repeat (6) begin
      #1;
      if (!ok && bus_reply === 1'b1) begin
        ok = 1'b1;
        rd = bus_rdata;
      end
      @(posedge hclk);
    end
  endtask : access
endmodule : ipc_peer_model

// ===== verification/tb_top.sv
// Self-checking bench for the interprocessor communication register block
`timescale 1ns/100ps
module tb_top
  import ipc_pkg::*;
();
  typedef struct packed {
    logic [7:0] a;
    logic [2:0] sz;
    logic [31:0] wd;
    logic [31:0] ex;
  } ipc_tb_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dc_power_good, bus_init, local_is_master;
  logic db_grant, bus_reply, mem_req, mem_write, mem_parity_err, db_irq, auxiliary_halt, irq, ok;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, role_strap;
  logic [2:0] hsize;
  logic [15:0] bus_rdata, mem_wdata, db_vector, prd;
  logic [IPC_MEM_AW-1:0] mem_addr;
  logic [4:0] interrupt_priority_level;
  logic [21:0] icr_a;
  ipc_bus_req_t bus_req;
  int fails, checked, i, n;
  ipc_tb_row_t rows [9] = '{
    '{8'h00, 3'h2, 32'h60, 32'h60}, '{8'h00, 3'h0, 32'h00, 32'h00},
    '{8'h00, 3'h0, 32'h9f, 32'h00}, '{8'h00, 3'h0, 32'h20, 32'h20},
    '{8'h01, 3'h0, 32'h7e00, 32'h20}, '{8'h00, 3'h2, 32'h40, 32'h40},
    '{8'h10, 3'h2, 32'h7, 32'h7}, '{8'h18, 3'h2, 32'hffffffff, 32'h0},
    '{8'h08, 3'h2, 32'h0, 32'h5}
  };

  ipc_comm_reg dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .role_strap(role_strap), .dc_power_good(dc_power_good),
    .bus_init(bus_init), .local_is_master(local_is_master), .bus_req(bus_req), .bus_reply(bus_reply),
    .bus_rdata(bus_rdata), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_parity_err(mem_parity_err), .db_grant(db_grant), .db_irq(db_irq),
    .interrupt_priority_level(interrupt_priority_level), .db_vector(db_vector),
    .auxiliary_halt(auxiliary_halt), .irq(irq));
  ipc_peer_model peer_u (.hclk(hclk), .bus_req(bus_req), .bus_reply(bus_reply), .bus_rdata(bus_rdata),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_parity_err(mem_parity_err));

  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Single slave always ready, but the master still waits for it
  task automatic wait_rdy();
    int k;
    for (k = 0; k < 20 && hreadyout !== 1'b1; k++) @(posedge hclk);
    if (k == 20) begin
      fails++;
      finish_test();
    end
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [2:0] sz, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= IPC_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    wait_rdy();
    rd = hrdata;
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
    ahb(1'b0, a, 3'h2, 32'h0);
    chk(rd, ex);
  endtask : rdc
  function automatic logic sig(input int s);
    return s == 0 ? db_irq : auxiliary_halt;
  endfunction : sig
  task automatic poll(input int s, input logic v);
    int k;
    for (k = 0; k < 12 && sig(s) !== v; k++) @(posedge hclk);
    chk(32'(sig(s)), 32'(v));
  endtask : poll
  task automatic do_reset(input logic [1:0] role);
    hresetn <= 1'b0;
    role_strap <= role;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : do_reset

  ////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    fails = 0;
    checked = 0;
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, bus_init, db_grant} = '0;
    {role_strap, dc_power_good, local_is_master} = {2'h1, 1'b1, 1'b1};
    icr_a = IPC_ICR_BUS_BASE + 22'h2;
    @(posedge hclk);
    do_reset(2'h1);
    chk(32'({hresp, hreadyout, db_irq, irq, auxiliary_halt}), 32'h8);
    rdc(IPC_ICR_OFF, 32'h0);
    for (i = 0; i < 9; i++) begin
      ahb(1'b1, rows[i].a, rows[i].sz, rows[i].wd);
      rdc(rows[i].a & 8'hfc, rows[i].ex);
    end
    // Doorbell rung by a peer while the board is not bus master
    local_is_master <= 1'b0;
    peer_u.access(1'b1, 1'b0, icr_a, 16'h0001, prd, ok);
    chk(32'(ok), 32'h1);
    poll(0, 1'b1);
    chk(32'({interrupt_priority_level, db_vector}), 32'({IPC_DB_IPL, IPC_DB_VECTOR}));
    chk(32'(irq), 32'h1);
    peer_u.access(1'b1, 1'b0, icr_a, 16'h0000, prd, ok);
    peer_u.access(1'b0, 1'b0, icr_a, 16'h0000, prd, ok);
    chk(32'(prd), 32'h41);
    rdc(IPC_IRQ_STAT_OFF, 32'h1);
    rdc(IPC_IRQ_STAT_OFF, 32'h0);
    @(posedge hclk);
    chk(32'(irq), 32'h0);
    db_grant <= 1'b1;
    @(posedge hclk);
    db_grant <= 1'b0;
    poll(0, 1'b0);
    rdc(IPC_ICR_OFF, 32'h40);
    ahb(1'b1, IPC_ICR_OFF, 3'h2, 32'h0);
    rdc(IPC_ICR_OFF, 32'h40);
    local_is_master <= 1'b1;
    ahb(1'b1, IPC_ICR_OFF, 3'h2, 32'h20);
    @(posedge hclk);
    local_is_master <= 1'b0;
    peer_u.access(1'b1, 1'b0, icr_a, 16'h0001, prd, ok);
    peer_u.access(1'b0, 1'b0, icr_a, 16'h0000, prd, ok);
    chk(32'({db_irq, prd}), 32'h20);
    // Map steering, a disabled entry, then a parity error
    ahb(1'b1, IPC_MAP_OFF, 3'h2, 32'h80010155);
    n = peer_u.hits;
    peer_u.access(1'b0, 1'b0, {9'h001, 13'h0abc}, 16'h0, prd, ok);
    chk(32'({ok, peer_u.last_addr}), 32'({1'b1, 11'h155, 13'h0abc}));
    peer_u.access(1'b0, 1'b0, {9'h002, 13'h0010}, 16'h0, prd, ok);
    chk({ok, 31'(peer_u.hits - n)}, 32'h1);
    peer_u.pe_inject <= 1'b1;
    peer_u.access(1'b1, 1'b0, {9'h001, 13'h0002}, 16'h1234, prd, ok);
    peer_u.pe_inject <= 1'b0;
    chk(32'({peer_u.last_wr, peer_u.last_wd}), 32'({1'b1, 16'h1234}));
    rdc(IPC_ICR_OFF, 32'h8020);
    rdc(IPC_ERR_OFF, 32'h10);
    rdc(IPC_IRQ_STAT_OFF, 32'h2);
    ahb(1'b1, IPC_ERR_OFF, 3'h2, 32'h10);
    rdc(IPC_ICR_OFF, 32'h20);
    local_is_master <= 1'b1;
    ahb(1'b1, IPC_ICR_OFF, 3'h2, 32'h0);
    @(posedge hclk);
    n = peer_u.hits;
    peer_u.access(1'b0, 1'b0, {9'h001, 13'h0abc}, 16'h0, prd, ok);
    chk({ok, 31'(peer_u.hits - n)}, 32'h0);
    // Halt from a peer, then both initialise paths
    peer_u.access(1'b1, 1'b1, icr_a + 22'h1, 16'h0100, prd, ok);
    poll(1, 1'b1);
    peer_u.access(1'b0, 1'b0, icr_a, 16'h0000, prd, ok);
    chk(32'(prd), 32'h100);
    rdc(IPC_IRQ_STAT_OFF, 32'h4);
    ahb(1'b1, IPC_ICR_OFF, 3'h2, 32'h160);
    bus_init <= 1'b1;
    repeat (2) @(posedge hclk);
    bus_init <= 1'b0;
    poll(1, 1'b0);
    rdc(IPC_ICR_OFF, 32'h0);
    ahb(1'b1, IPC_ICR_OFF, 3'h2, 32'h60);
    dc_power_good <= 1'b0;
    repeat (4) @(posedge hclk);
    dc_power_good <= 1'b1;
    repeat (6) @(posedge hclk);
    rdc(IPC_ICR_OFF, 32'h0);
    // Arbiter strap: own address, halt bit dead
    do_reset(2'h0);
    peer_u.access(1'b1, 1'b0, IPC_ICR_BUS_BASE, 16'h0100, prd, ok);
    peer_u.access(1'b0, 1'b0, IPC_ICR_BUS_BASE, 16'h0000, prd, ok);
    chk(32'({ok, auxiliary_halt, prd}), 32'h20000);
    peer_u.access(1'b0, 1'b0, icr_a, 16'h0000, prd, ok);
    chk(32'(ok), 32'h0);
    rdc(IPC_CTRL_OFF, 32'h0);
    finish_test();
  end
endmodule : tb_top
